//--- include/prs_defs.vh
// Constants for the projector rail sequencer and strobe decoder.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef PRS_DEFS_VH
`define PRS_DEFS_VH
`define PRS_CLK_HZ         10000000
`define PRS_OFS_DELAY_MS   100
`define PRS_RAIL_DELAY_MS  10
`define PRS_DEGLITCH_MS    1
`define PRS_SEL_FILTER_NS  300
`define PRS_OFS_CYC    ((`PRS_CLK_HZ / 1000) * `PRS_OFS_DELAY_MS)
`define PRS_RAIL_CYC   ((`PRS_CLK_HZ / 1000) * `PRS_RAIL_DELAY_MS)
`define PRS_DGL_CYC    (((`PRS_CLK_HZ / 1000) * `PRS_DEGLITCH_MS))
`define PRS_SEL_CYC    (((`PRS_CLK_HZ / 1000000) * `PRS_SEL_FILTER_NS + 999) / 1000)
`define PRS_WARN_ON_C   8'd120
`define PRS_WARN_HYST_C 8'd10
`define PRS_TSD_ON_C    8'd150
`define PRS_TSD_HYST_C  8'd15
`define PRS_ST_OFF      2'h0
`define PRS_ST_WAIT     2'h1
`define PRS_ST_OFS      2'h2
`define PRS_ST_ON       2'h3
`define PRS_SW_NONE     6'h00
`define PRS_CA_UPPER    6'h07
`define PRS_CA_LOW1     6'h08
`define PRS_CA_LOW2     6'h10
`define PRS_CA_LOW3     6'h20
`define PRS_CCA_1       6'h21
`define PRS_CCA_2       6'h1c
`define PRS_CCA_3       6'h1a
`define PRS_CUR_W       10
`endif

//--- core/prs_sequencer.v
// Rail sequencer, fault shutdown, thermal flags and six-switch strobe decoder.
// Assumes all inputs synchronous to clk_sys; serial port decoded elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "prs_defs.vh"

// ----------------------------------------------------------------
// Level deglitch filter
// ----------------------------------------------------------------
// A new level is taken only after it has stood CYC enabled clocks.
// Any bounce restarts the count, so a chattering pin never gets through.
module prs_deglitch #(
  parameter integer CYC   = 5,
  parameter integer CNT_W = 21
) (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire clk_en,
  input  wire level_in,
  output reg  level_ff
);

  reg [CNT_W-1:0] cnt_ff;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= 1'b0;
      cnt_ff   <= {CNT_W{1'b0}};
    end else if (clk_en) begin
      if (level_in == level_ff) begin
        cnt_ff <= {CNT_W{1'b0}};
      end else if (cnt_ff == CYC[CNT_W-1:0] - 1'b1) begin
        level_ff <= level_in;
        cnt_ff   <= {CNT_W{1'b0}};
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

endmodule // prs_deglitch

// ----------------------------------------------------------------
// Sequencer top
// ----------------------------------------------------------------
module prs_sequencer #(
  parameter integer OFS_CYC  = `PRS_OFS_CYC,
  parameter integer RAIL_CYC = `PRS_RAIL_CYC,
  parameter integer DGL_CYC  = `PRS_DGL_CYC,
  parameter integer SEL_CYC  = `PRS_SEL_CYC,
  parameter integer CNT_W    = 21
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        clk_en,
  input  wire        projector_power_request,
  input  wire        test_in,
  input  wire [1:0]  color_select,
  input  wire        package_layout,
  input  wire        mirror_rails_enable,
  input  wire        led_supply_enable,
  input  wire [2:0]  rail_fault,
  input  wire [7:0]  die_temp_c,
  input  wire [7:0]  switch_dead_time,
  input  wire [29:0] channel_current_code,
  input  wire [2:0]  transient_limit_code,
  input  wire [1:0]  measure_gain_code,
  output reg         offset_rail_ff,
  output reg         bias_rail_ff,
  output reg         negative_reset_rail_ff,
  output reg         full_active_state_ff,
  output reg         led_driver_en_ff,
  output reg  [5:0]  switch_gate_ff,
  output reg  [9:0]  active_current_code_ff,
  output reg  [2:0]  limit_code_ff,
  output reg  [1:0]  gain_code_ff,
  output reg         test_mode_ff,
  output reg         hot_warning_ff,
  output reg         thermal_shutdown_flag_ff
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg rst_meta_ff;
  reg rst_sync_n_ff;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff   <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_ff   <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Deglitch filters
  // ----------------------------------------------------------------
  wire            req_dg;
  wire            tst_dg;
  reg [1:0]       sel_dg_ff;
  reg [7:0]       sel_cnt_ff;
  reg [1:0]       sel_last_ff;

  // Power request: a long filter, so a glitch never starts the rails
  prs_deglitch #(
    .CYC   (DGL_CYC),
    .CNT_W (CNT_W)
  ) i_req_dg (
    .clk_sys  (clk_sys),
    .rst_n    (rst_sync_n_ff),
    .clk_en   (clk_en),
    .level_in (projector_power_request),
    .level_ff (req_dg)
  );

  // Test pin uses the same filter length
  prs_deglitch #(
    .CYC   (DGL_CYC),
    .CNT_W (CNT_W)
  ) i_tst_dg (
    .clk_sys  (clk_sys),
    .rst_n    (rst_sync_n_ff),
    .clk_en   (clk_en),
    .level_in (test_in),
    .level_ff (tst_dg)
  );

  // Select filter is short; a code must stand SEL_CYC+1 clocks
  always @(posedge clk_sys or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      sel_dg_ff   <= 2'h0;
      sel_cnt_ff  <= 8'h00;
      sel_last_ff <= 2'h0;
    end else if (clk_en) begin
      sel_last_ff <= color_select;
      if (color_select != sel_last_ff) begin
        sel_cnt_ff <= 8'h00;
      end else if (sel_cnt_ff < SEL_CYC[7:0] - 8'h01) begin
        sel_cnt_ff <= sel_cnt_ff + 8'h01;
      end else begin
        sel_dg_ff <= sel_last_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Rail sequencer
  // ----------------------------------------------------------------
  reg [1:0]       state_ff;
  reg [CNT_W-1:0] seq_cnt_ff;
  reg [1:0]       nxt_state;
  wire            any_fault = |rail_fault;
  wire            rails_ok  = offset_rail_ff & bias_rail_ff & negative_reset_rail_ff;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `PRS_ST_OFF:  if (req_dg && mirror_rails_enable) nxt_state = `PRS_ST_WAIT;
      `PRS_ST_WAIT: if (seq_cnt_ff == OFS_CYC[CNT_W-1:0] - 1'b1) nxt_state = `PRS_ST_OFS;
      `PRS_ST_OFS:  if (seq_cnt_ff == RAIL_CYC[CNT_W-1:0] - 1'b1) nxt_state = `PRS_ST_ON;
      `PRS_ST_ON:   nxt_state = `PRS_ST_ON;
      default:      nxt_state = `PRS_ST_OFF;
    endcase
    // Fault latches off until the request is dropped and raised again
    if (!req_dg || !mirror_rails_enable) nxt_state = `PRS_ST_OFF;
  end

  reg fault_lock_ff;
  always @(posedge clk_sys or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      state_ff               <= `PRS_ST_OFF;
      seq_cnt_ff             <= {CNT_W{1'b0}};
      fault_lock_ff          <= 1'b0;
      offset_rail_ff         <= 1'b0;
      bias_rail_ff           <= 1'b0;
      negative_reset_rail_ff <= 1'b0;
      full_active_state_ff   <= 1'b0;
      led_driver_en_ff       <= 1'b0;
    end else if (clk_en) begin
      if (any_fault || thermal_shutdown_flag_ff) fault_lock_ff <= 1'b1;
      else if (!req_dg) fault_lock_ff <= 1'b0;
      state_ff   <= (fault_lock_ff || any_fault) ? `PRS_ST_OFF : nxt_state;
      seq_cnt_ff <= (nxt_state != state_ff) ? {CNT_W{1'b0}} : seq_cnt_ff + 1'b1;
      if (any_fault || fault_lock_ff) begin
        offset_rail_ff         <= 1'b0;
        bias_rail_ff           <= 1'b0;
        negative_reset_rail_ff <= 1'b0;
      end else begin
        offset_rail_ff         <= (nxt_state == `PRS_ST_OFS) || (nxt_state == `PRS_ST_ON);
        bias_rail_ff           <= (nxt_state == `PRS_ST_ON);
        negative_reset_rail_ff <= (nxt_state == `PRS_ST_ON);
      end
      full_active_state_ff <= rails_ok && !any_fault && led_supply_enable;
      led_driver_en_ff     <= rails_ok && !any_fault && !fault_lock_ff
                              && led_supply_enable;
    end
  end

  // ----------------------------------------------------------------
  // Strobe decoder with break-before-make
  // ----------------------------------------------------------------
  reg [5:0] target;
  always @* begin
    target = `PRS_SW_NONE;
    if (!package_layout) begin
      case (sel_dg_ff)
        2'h1:    target = `PRS_CA_UPPER | `PRS_CA_LOW1;
        2'h2:    target = `PRS_CA_UPPER | `PRS_CA_LOW2;
        2'h3:    target = `PRS_CA_UPPER | `PRS_CA_LOW3;
        default: target = `PRS_CA_UPPER;
      endcase
    end else begin
      case (sel_dg_ff)
        2'h1:    target = `PRS_CCA_1;
        2'h2:    target = `PRS_CCA_2;
        2'h3:    target = `PRS_CCA_3;
        default: target = `PRS_SW_NONE;
      endcase
    end
    if (!led_driver_en_ff) target = `PRS_SW_NONE;
  end

  reg [7:0] dead_cnt_ff;
  always @(posedge clk_sys or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      switch_gate_ff         <= `PRS_SW_NONE;
      dead_cnt_ff            <= 8'h00;
      active_current_code_ff <= {`PRS_CUR_W{1'b0}};
    end else if (clk_en) begin
      // Opens go out at once; closures wait so no two paths ever overlap
      if (target == switch_gate_ff) begin
        dead_cnt_ff <= 8'h00;
      end else if ((switch_gate_ff & ~target) != 6'h00) begin
        switch_gate_ff <= switch_gate_ff & target;
        dead_cnt_ff    <= 8'h00;
      end else if (dead_cnt_ff >= switch_dead_time) begin
        switch_gate_ff <= target;
      end else begin
        dead_cnt_ff <= dead_cnt_ff + 8'h01;
      end
      case (sel_dg_ff)
        2'h1:    active_current_code_ff <= channel_current_code[9:0];
        2'h2:    active_current_code_ff <= channel_current_code[19:10];
        2'h3:    active_current_code_ff <= channel_current_code[29:20];
        default: active_current_code_ff <= {`PRS_CUR_W{1'b0}};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Codes passed to the analog side and thermal flags
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      limit_code_ff            <= 3'h0;
      gain_code_ff             <= 2'h0;
      test_mode_ff             <= 1'b0;
      hot_warning_ff           <= 1'b0;
      thermal_shutdown_flag_ff <= 1'b0;
    end else if (clk_en) begin
      limit_code_ff <= transient_limit_code;
      gain_code_ff  <= measure_gain_code;
      test_mode_ff  <= tst_dg;
      // Hysteresis keeps the flags from chattering near a threshold
      if (die_temp_c > `PRS_WARN_ON_C) begin
        hot_warning_ff <= 1'b1;
      end else if (die_temp_c <= `PRS_WARN_ON_C - `PRS_WARN_HYST_C) begin
        hot_warning_ff <= 1'b0;
      end
      // Shutdown also latches the rails off until the request drops
      if (die_temp_c >= `PRS_TSD_ON_C) begin
        thermal_shutdown_flag_ff <= 1'b1;
      end else if (die_temp_c <= `PRS_TSD_ON_C - `PRS_TSD_HYST_C) begin
        thermal_shutdown_flag_ff <= 1'b0;
      end
    end
  end

endmodule // prs_sequencer
`default_nettype wire

//--- tb/prs_host_model.sv
// Display controller model: power request, color select and config bits.
// Levels change only just after a falling edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module prs_host_model (
  input  wire       clk_sys,
  output reg        projector_power_request,
  output reg  [1:0] color_select,
  output reg        mirror_rails_enable,
  output reg        led_supply_enable
);
  // Host starts both enables at their reset value
  initial begin
    projector_power_request = 1'b0;
    color_select            = 2'h0;
    mirror_rails_enable     = 1'b1;
    led_supply_enable       = 1'b1;
  end
  task set_en(input reg [1:0] v);
    begin
      @(negedge clk_sys);
      {mirror_rails_enable, led_supply_enable} = v;
    end
  endtask
  task set_req(input reg v);
    begin
      @(negedge clk_sys);
      projector_power_request = v;
    end
  endtask
  task set_sel(input reg [1:0] v);
    begin
      @(negedge clk_sys);
      color_select = v;
    end
  endtask
endmodule // prs_host_model
`default_nettype wire

//--- tb/prs_seq_properties.sv
// Port checker for the rail sequencer, bound below.
// Assumes registered outputs one edge after their cause.
`timescale 1ns/1ps
`default_nettype none
module prs_seq_chk #(parameter integer OFS_CYC = 50) (
  input wire       clk_sys,
  input wire       rstn,
  input wire       clk_en,
  input wire       projector_power_request,
  input wire [2:0] rail_fault,
  input wire [7:0] die_temp_c,
  input wire       offset_rail_ff,
  input wire       bias_rail_ff,
  input wire       negative_reset_rail_ff,
  input wire       led_driver_en_ff,
  input wire [5:0] switch_gate_ff,
  input wire       hot_warning_ff,
  input wire       thermal_shutdown_flag_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire rails_on = offset_rail_ff | bias_rail_ff | negative_reset_rail_ff;
  wire all_on = offset_rail_ff & bias_rail_ff & negative_reset_rail_ff;
  property p_fault; clk_en && |rail_fault |=> !rails_on; endproperty
  a_fault: assert property (p_fault) else $error("rail on after fault");
  property p_pair; bias_rail_ff |-> all_on; endproperty
  a_pair: assert property (p_pair) else $error("rail order");
  property p_gap; $rose(bias_rail_ff) |-> $past(offset_rail_ff, 8); endproperty
  a_gap: assert property (p_gap) else $error("bias too early");
  property p_dgl; $rose(offset_rail_ff) |-> $past(projector_power_request, OFS_CYC);
  endproperty
  a_dgl: assert property (p_dgl) else $error("offset too early");
  property p_drv; $rose(led_driver_en_ff) |-> all_on; endproperty
  a_drv: assert property (p_drv) else $error("driver before rails");
  property p_open; !led_driver_en_ff [*2] |-> switch_gate_ff == 6'h00; endproperty
  a_open: assert property (p_open) else $error("switch closed");
  property p_bbm;
    |(switch_gate_ff & ~$past(switch_gate_ff)) |-> !(|($past(switch_gate_ff) & ~switch_gate_ff));
  endproperty
  a_bbm: assert property (p_bbm) else $error("make before break");
  property p_hot; clk_en && die_temp_c > 8'd120 |=> hot_warning_ff; endproperty
  a_hot: assert property (p_hot) else $error("no hot flag");
  property p_hyst; clk_en && hot_warning_ff && die_temp_c > 8'd110 |=> hot_warning_ff;
  endproperty
  a_hyst: assert property (p_hyst) else $error("hot cleared early");
  property p_tsd; clk_en && die_temp_c >= 8'd150 |=> thermal_shutdown_flag_ff; endproperty
  a_tsd: assert property (p_tsd) else $error("no shutdown");
  c_up: cover property ($rose(bias_rail_ff));
  c_fault: cover property (|rail_fault && offset_rail_ff);
  c_tsd: cover property ($rose(thermal_shutdown_flag_ff));
endmodule // prs_seq_chk
bind prs_sequencer prs_seq_chk #(.OFS_CYC(OFS_CYC)) i_chk (.clk_sys(clk_sys), .rstn(rstn),
  .clk_en(clk_en), .projector_power_request(projector_power_request),
  .rail_fault(rail_fault), .die_temp_c(die_temp_c), .offset_rail_ff(offset_rail_ff),
  .bias_rail_ff(bias_rail_ff), .negative_reset_rail_ff(negative_reset_rail_ff),
  .led_driver_en_ff(led_driver_en_ff), .switch_gate_ff(switch_gate_ff),
  .hot_warning_ff(hot_warning_ff), .thermal_shutdown_flag_ff(thermal_shutdown_flag_ff));
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the rail sequencer with shortened counts.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg en = 1'b1, tst = 1'b0, lay = 1'b0;
  reg [2:0] flt = 3'h0, lim = 3'h0;
  reg [7:0] tmp = 8'd25;
  reg [1:0] gn = 2'h1;
  reg [7:0] dt = 8'h02;
  reg [29:0] cc = {10'h333, 10'h222, 10'h111};
  wire req, mre, lse, ofs, bia, nrr, fas, drv, tm, hot, thermal_shutdown_flag;
  wire [1:0] sel, gno;
  wire [2:0] lmo;
  wire [5:0] sw;
  wire [9:0] cur;
  // Expected switch words, layout 0 then layout 1
  wire [47:0] swt = {6'h1a, 6'h1c, 6'h21, 6'h00, 6'h27, 6'h17, 6'h0f, 6'h07};
  wire [59:0] tt = {10'h21e, 10'h223, 10'h25b, 10'h1b8, 10'h1be, 10'h1e6};
  integer num_errors = 0, cmp_count = 0, i, t0;
  always #50 clk_sys = ~clk_sys;
  prs_host_model i_host (.clk_sys(clk_sys), .projector_power_request(req),
    .color_select(sel), .mirror_rails_enable(mre), .led_supply_enable(lse));
  prs_sequencer #(.OFS_CYC(50), .RAIL_CYC(10), .DGL_CYC(5), .SEL_CYC(3)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(en), .projector_power_request(req),
    .test_in(tst), .color_select(sel), .package_layout(lay), .mirror_rails_enable(mre),
    .led_supply_enable(lse), .rail_fault(flt), .die_temp_c(tmp), .switch_dead_time(dt),
    .channel_current_code(cc), .transient_limit_code(lim),
    .measure_gain_code(gn), .offset_rail_ff(ofs), .bias_rail_ff(bia),
    .negative_reset_rail_ff(nrr), .full_active_state_ff(fas), .led_driver_en_ff(drv),
    .switch_gate_ff(sw), .active_current_code_ff(cur), .limit_code_ff(lmo),
    .gain_code_ff(gno), .test_mode_ff(tm), .hot_warning_ff(hot),
    .thermal_shutdown_flag_ff(thermal_shutdown_flag));
  task cyc(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait on the offset rail (0) or the bias rail (1)
  task wait_up(input integer b);
    begin
      t0 = 0;
      while ((b ? bia : ofs) !== 1'b1 && t0 < 200) begin
        cyc(1);
        t0 = t0 + 1;
      end
    end
  endtask
  task end_of_test;
    begin
      if (num_errors == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    #300000;
    num_errors = num_errors + 1;
    end_of_test;
  end
  initial begin
    cyc(5);
    rstn = 1'b1;
    cyc(3);
    chk({ofs, bia, nrr, drv, sw}, 32'h0);
    i_host.set_req(1'b1);
    cyc(3);
    i_host.set_req(1'b0);
    cyc(80);
    chk(ofs, 1'b0);
    i_host.set_req(1'b1);
    wait_up(0);
    chk(t0 >= 55 && t0 <= 60, 1'b1);
    wait_up(1);
    chk({t0 >= 9 && t0 <= 11, nrr}, 2'h3);
    cyc(4);
    chk({fas, drv}, 2'h3);
    for (i = 0; i < 8; i = i + 1) begin
      lay = i[2];
      i_host.set_sel(i[1:0]);
      cyc(12);
      chk({cur, sw}, {10'h111 * i[1:0], swt[i*6 +: 6]});
    end
    i_host.set_sel(2'h1);
    i_host.set_sel(2'h3);
    cyc(3);
    chk(sw, 6'h1a);
    for (i = 0; i < 8; i = i + 1) begin
      lim = i[2:0];
      gn = i[1:0];
      cyc(2);
      chk({lmo, gno}, {i[2:0], i[1:0]});
    end
    tst = 1'b1;
    cyc(3);
    chk(tm, 1'b0);
    cyc(10);
    chk(tm, 1'b1);
    i_host.set_en(2'b01);
    cyc(2);
    chk({ofs, bia, nrr}, 3'h0);
    i_host.set_en(2'b11);
    i_host.set_req(1'b0);
    cyc(12);
    chk({ofs, bia, nrr}, 3'h0);
    i_host.set_req(1'b1);
    wait_up(1);
    cyc(6);
    flt = 3'h4;
    cyc(2);
    chk({ofs, bia, nrr}, 3'h0);
    flt = 3'h0;
    cyc(10);
    chk({ofs, sw}, 7'h00);
    for (i = 0; i < 6; i = i + 1) begin
      tmp = tt[i*10+2 +: 8];
      cyc(3);
      chk({hot, thermal_shutdown_flag}, tt[i*10 +: 2]);
    end
    en = 1'b0;
    tmp = 8'd25;
    cyc(3);
    chk(hot, 1'b1);
    en = 1'b1;
    cyc(3);
    chk(hot, 1'b0);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
